// *** logic/fss_state_machine.sv ***
`timescale 1ns/1ps
`include "fss_defines.svh"
module fss_state_machine #(
    parameter int OUT_W = 16,
    parameter int IN_W  = 16
) (
    // clock and reset
    input  wire logic                 mclk,
    input  wire logic                 rst,
    // state request from master (same clock)
    input  wire fss_pkg::fss_req_s    req,
    input  wire fss_pkg::fss_cfg_s    cfg,
    input  wire logic                 outDataValid,
    input  wire logic [OUT_W-1:0]     outData,
    // watchdog control
    input  wire logic                 watchdogEn,
    // physical inputs from pins
    input  wire logic [IN_W-1:0]      inPins,
    // status
    output fss_pkg::fss_state_e       state,
    output logic                      ack,
    output logic                      errFlag,
    output logic [3:0]                errCode,
    output fss_pkg::fss_allow_s       allow,
    // physical outputs and input image
    output logic [OUT_W-1:0]          outPins,
    output logic [IN_W-1:0]           inImage
);
    import fss_pkg::*;

    // =================================================================
    // pin synchroniser
    logic [IN_W-1:0] inMeta;
    logic [IN_W-1:0] inSync;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            inMeta <= '0;
            inSync <= '0;
        end else begin
            inMeta <= inPins;
            inSync <= inMeta;
        end
    end

    // =================================================================
    // transition decode
    fss_state_e next_state;
    logic       legal;
    logic [3:0] chkErr;
    logic       goSafe;
    logic       needCopy;
    logic [3:0] copyCnt;
    logic       copying;

    function automatic logic isLegal(input fss_state_e s,
                                     input logic [3:0] c);
        unique case (c)
            `FSS_REQ_INIT:   isLegal = 1'b1;
            `FSS_REQ_PREOP:  isLegal = (s == FSS_INIT) || (s == FSS_SAFEOP)
                                    || (s == FSS_OP) || (s == FSS_PREOP);
            `FSS_REQ_BOOT:   isLegal = (s == FSS_INIT)
                                    || (s == FSS_BOOT);
            `FSS_REQ_SAFEOP: isLegal = (s == FSS_PREOP) || (s == FSS_OP)
                                    || (s == FSS_SAFEOP);
            `FSS_REQ_OP:     isLegal = (s == FSS_SAFEOP)
                                    || (s == FSS_OP);
            default:         isLegal = 1'b0;
        endcase
    endfunction : isLegal

    function automatic fss_state_e codeToState(input logic [3:0] c);
        unique case (c)
            `FSS_REQ_PREOP:  codeToState = FSS_PREOP;
            `FSS_REQ_BOOT:   codeToState = FSS_BOOT;
            `FSS_REQ_SAFEOP: codeToState = FSS_SAFEOP;
            `FSS_REQ_OP:     codeToState = FSS_OP;
            default:         codeToState = FSS_INIT;
        endcase
    endfunction : codeToState

    wire fss_state_e target = codeToState(req.code);
    wire logic mbxOk  = cfg.mbxOutOk && cfg.mbxInOk;
    wire logic dcOk   = !cfg.dcUsed || cfg.dcOk;
    wire logic upPre  = (state == FSS_INIT) && (target == FSS_PREOP);
    wire logic upSafe = (state == FSS_PREOP) && (target == FSS_SAFEOP);
    wire logic upOp   = (state == FSS_SAFEOP) && (target == FSS_OP);
    wire logic takeReq = req.valid && !copying;

    always_comb begin
        legal = isLegal(state, req.code);
        if (!legal) begin
            chkErr = `FSS_ERR_BADREQ;
        end else if (upPre && !mbxOk) begin
            chkErr = `FSS_ERR_MBXCFG;
        end else if (upSafe && !cfg.pdChOk) begin
            chkErr = `FSS_ERR_PDCFG;
        end else if (upSafe && !dcOk) begin
            chkErr = `FSS_ERR_DCCFG;
        end else if (upOp && !outDataValid) begin
            chkErr = `FSS_ERR_NOOUT;
        end else begin
            chkErr = `FSS_ERR_NONE;
        end
    end

    // entering safe_operational_state from preoperational_state needs the input copy first
    assign needCopy = upSafe && (chkErr == `FSS_ERR_NONE);
    assign goSafe   = copying && (copyCnt == `FSS_COPY_CYCLES);

    always_comb begin
        next_state = state;
        if (goSafe) begin
            next_state = FSS_SAFEOP;
        end else if (takeReq && chkErr == `FSS_ERR_NONE && !needCopy) begin
            next_state = target;
        end
    end

    // =================================================================
    // state, acknowledge and error
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state   <= FSS_INIT;
            ack     <= 1'b0;
            errFlag <= 1'b0;
            errCode <= `FSS_ERR_NONE;
            copying <= 1'b0;
            copyCnt <= 4'h0;
        end else begin
            state <= next_state;
            ack   <= goSafe || (takeReq && chkErr == `FSS_ERR_NONE
                                && !needCopy);
            if (takeReq && chkErr != `FSS_ERR_NONE) begin
                errFlag <= 1'b1;
                errCode <= chkErr;
            end else if (takeReq) begin
                errFlag <= 1'b0;
                errCode <= `FSS_ERR_NONE;
            end
            if (takeReq && needCopy) begin
                copying <= 1'b1;
                copyCnt <= 4'h0;
            end else if (goSafe) begin
                copying <= 1'b0;
            end else if (copying) begin
                copyCnt <= copyCnt + 4'h1;
            end
        end
    end

    // =================================================================
    // exchange permissions per state
    fss_allow_s next_allow;

    always_comb begin
        next_allow = '0;
        unique case (next_state)
            FSS_INIT:   next_allow = '0;
            FSS_PREOP:  next_allow.mailboxEn = 1'b1;
            FSS_SAFEOP: next_allow = 4'b1011;
            FSS_OP:     next_allow = 4'b1011;
            FSS_BOOT:   next_allow = 4'b1100;
        endcase
    end

    // =================================================================
    // physical outputs and input image
    wire logic driveOut = (next_state == FSS_OP)
                       || (next_state == FSS_SAFEOP && !watchdogEn);
    wire logic imgWr = (copying && !goSafe)
                    || (state == FSS_SAFEOP) || (state == FSS_OP);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            allow   <= '0;
            outPins <= OUT_W'(`FSS_OUT_SAFE);
        end else begin
            allow <= next_allow;
            if (driveOut) begin
                outPins <= outData;
            end else begin
                outPins <= OUT_W'(`FSS_OUT_SAFE);
            end
        end
    end

    fss_input_image #(
        .WIDTH (IN_W)
    ) uImage (
        .mclk   (mclk),
        .rst    (rst),
        .wrEn   (imgWr),
        .wrData (inSync),
        .rdData (inImage)
    );
endmodule : fss_state_machine

// *** logic/fss_defines.svh ***
`ifndef FSS_DEFINES_SVH
`define FSS_DEFINES_SVH

// =====================================================================
// state request codes
`define FSS_REQ_INIT    4'h1
`define FSS_REQ_PREOP   4'h2
`define FSS_REQ_BOOT    4'h3
`define FSS_REQ_SAFEOP  4'h4
`define FSS_REQ_OP      4'h8

// =====================================================================
// buffer channel numbers
`define FSS_MBX_CH_OUT  3'h0
`define FSS_MBX_CH_IN   3'h1
`define FSS_PD_CH_FIRST 3'h2

// =====================================================================
// reset values, error codes and copy length
`define FSS_OUT_SAFE    16'h0000
`define FSS_ERR_NONE    4'h0
`define FSS_ERR_BADREQ  4'h1
`define FSS_ERR_MBXCFG  4'h2
`define FSS_ERR_PDCFG   4'h3
`define FSS_ERR_DCCFG   4'h4
`define FSS_ERR_NOOUT   4'h5
`define FSS_COPY_CYCLES 4'h2
`endif

// *** logic/fss_pkg.sv ***
package fss_pkg;
    typedef enum logic [2:0] {
        FSS_INIT, FSS_PREOP, FSS_SAFEOP, FSS_OP, FSS_BOOT
    } fss_state_e;

    // master-side state request with its checked configuration
    typedef struct packed {
        logic       valid;
        logic [3:0] code;
    } fss_req_s;

    typedef struct packed {
        logic mbxOutOk;   // channel 0 set up as mailbox out
        logic mbxInOk;    // channel 1 set up as mailbox in
        logic pdChOk;     // process channels from channel 2 set up
        logic dcUsed;
        logic dcOk;
    } fss_cfg_s;

    typedef struct packed {
        logic mailboxEn;
        logic fileOnly;
        logic processEn;
        logic inputRefresh;
    } fss_allow_s;
endpackage : fss_pkg

// *** logic/fss_input_image.sv ***
`timescale 1ns/1ps
`include "fss_defines.svh"
// input image kept in the dual-port memory area; registered read port
module fss_input_image #(
    parameter int WIDTH = 16
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rst,
    // write side
    input  wire logic             wrEn,
    input  wire logic [WIDTH-1:0] wrData,
    // read side
    output logic      [WIDTH-1:0] rdData
);
    logic [WIDTH-1:0] image;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            image  <= '0;
            rdData <= '0;
        end else begin
            if (wrEn) begin
                image <= wrData;
            end
            rdData <= image;
        end
    end
endmodule : fss_input_image

// *** verif/fss_state_machine_props.sv ***
`timescale 1ns/1ps
`include "fss_defines.svh"
module fss_state_machine_props (
    // clock and reset
    input wire logic                mclk,
    input wire logic                rst,
    // request side
    input wire fss_pkg::fss_req_s   req,
    input wire fss_pkg::fss_cfg_s   cfg,
    input wire logic [15:0]         outData,
    input wire logic                watchdogEn,
    // status side
    input wire fss_pkg::fss_state_e state,
    input wire logic                ack,
    input wire logic                errFlag,
    input wire logic [3:0]          errCode,
    input wire fss_pkg::fss_allow_s allow,
    input wire logic [15:0]         outPins
);
    import fss_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // ==========================================================
    // request sequences
    sequence s_req(c, st);
        req.valid && req.code == c && state == st;
    endsequence
    sequence s_copy_wait;
        (!ack)[*3] ##1 (ack && state == FSS_SAFEOP);
    endsequence
    // ==========================================================
    // assertions
    a_init_quiet: assert property (
        state == FSS_INIT |-> allow == 4'h0)
        else $error("init state allows traffic");
    a_mbx_check: assert property (
        s_req(`FSS_REQ_PREOP, FSS_INIT) ##0 !(cfg.mbxOutOk && cfg.mbxInOk)
        |=> state == FSS_INIT && errFlag && errCode == `FSS_ERR_MBXCFG)
        else $error("bad mailbox setup accepted");
    a_preop_ack: assert property (
        s_req(`FSS_REQ_PREOP, FSS_INIT) ##0 (cfg.mbxOutOk && cfg.mbxInOk)
        |=> ack && state == FSS_PREOP && !errFlag)
        else $error("good mailbox setup not acknowledged");
    a_preop_mbx: assert property (
        state == FSS_PREOP |-> allow == 4'h8)
        else $error("preop allow mismatch");
    a_pd_check: assert property (
        s_req(`FSS_REQ_SAFEOP, FSS_PREOP) ##0 !cfg.pdChOk
        |=> state == FSS_PREOP && errFlag && errCode == `FSS_ERR_PDCFG)
        else $error("bad process channel setup accepted");
    a_copy_ack: assert property (
        s_req(`FSS_REQ_SAFEOP, FSS_PREOP)
        ##0 (cfg.pdChOk && (!cfg.dcUsed || cfg.dcOk))
        |-> ##1 s_copy_wait)
        else $error("safeop ack timing wrong");
    a_safe_out: assert property (
        state == FSS_SAFEOP && $past(state) == FSS_SAFEOP
        && $past(watchdogEn) |-> outPins == 16'h0000)
        else $error("outputs driven in safeop");
    a_op_follow: assert property (
        state == FSS_OP && $past(state) == FSS_OP
        |-> outPins == $past(outData))
        else $error("outputs do not follow data");
    a_boot_entry: assert property (
        $rose(state == FSS_BOOT) |-> $past(state) == FSS_INIT)
        else $error("boot entered from wrong state");
    a_boot_file: assert property (
        state == FSS_BOOT |-> allow == 4'hC)
        else $error("boot allow mismatch");
    a_bad_keep: assert property (
        s_req(`FSS_REQ_OP, FSS_INIT)
        |=> state == FSS_INIT && errFlag && errCode == `FSS_ERR_BADREQ)
        else $error("illegal request not refused");
endmodule : fss_state_machine_props

bind fss_state_machine fss_state_machine_props u_fss_state_machine_props (
    .mclk(mclk), .rst(rst), .req(req), .cfg(cfg), .outData(outData),
    .watchdogEn(watchdogEn), .state(state), .ack(ack), .errFlag(errFlag),
    .errCode(errCode), .allow(allow), .outPins(outPins));

// *** verif/fss_master_model.sv ***
`timescale 1ns/1ps
module fss_master_model (
    // clock
    input wire logic         mclk,
    // request side
    output fss_pkg::fss_req_s req,
    output fss_pkg::fss_cfg_s cfg,
    output logic             outDataValid,
    output logic [15:0]      outData
);
    import fss_pkg::*;
    initial begin
        req = '0;
        cfg = 5'h1F;
        outDataValid = 1'b0;
        outData = 16'h3C96;
    end
    // ==========================================================
    // one request pulse; setup and data stay as levels afterwards
    // k carries the channel setup (mailbox 0/1, process from 2)
    task automatic send(input logic [3:0] c, input fss_cfg_s k,
                        input logic v);
        @(posedge mclk);
        #1;
        cfg = k;
        outDataValid = v;
        req = '{1'b1, c};
        @(posedge mclk);
        #1;
        req.valid = 1'b0;
    endtask : send
endmodule : fss_master_model

// *** verif/fss_state_machine_bench.sv ***
`timescale 1ns/1ps
`include "fss_defines.svh"
module fss_state_machine_bench;
    import fss_pkg::*;
    logic mclk = 0, rst = 1, watchdogEn = 1, ack, errFlag;
    logic [15:0] inPins = 16'hA5C3, outData, outPins, inImage;
    logic [3:0] errCode;
    logic outDataValid;
    fss_req_s req;
    fss_cfg_s cfg;
    fss_state_e state;
    fss_allow_s allow;
    int n_mismatch = 0, comparisons = 0, cyc = 0;
    always #12.5 mclk = ~mclk;
    fss_master_model u_fss_master_model (.mclk(mclk), .req(req),
        .cfg(cfg), .outDataValid(outDataValid), .outData(outData));
    fss_state_machine u_fss_state_machine (.mclk(mclk), .rst(rst),
        .req(req), .cfg(cfg), .outDataValid(outDataValid),
        .outData(outData), .watchdogEn(watchdogEn), .inPins(inPins),
        .state(state), .ack(ack), .errFlag(errFlag), .errCode(errCode),
        .allow(allow), .outPins(outPins), .inImage(inImage));
    // ==========================================================
    // shared helpers
    task automatic report_and_stop;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // waits past the longest answer (copy ack) before judging
    task automatic go(input logic [3:0] c, input fss_cfg_s k,
        input logic v, input fss_state_e s, input logic [3:0] e);
        u_fss_master_model.send(c, k, v);
        repeat (4) @(posedge mclk);
        #1;
        chk(16'(state), 16'(s));
        chk(16'(errCode), 16'(e));
        chk(16'(errFlag), 16'(e != `FSS_ERR_NONE));
    endtask : go
    // ==========================================================
    // scenarios
    task automatic t_reset;
        chk(16'(state), 16'(FSS_INIT));
        chk(16'(allow), 16'h0);
    endtask : t_reset
    task automatic t_preop;
        go(`FSS_REQ_OP, 5'h1F, 0, FSS_INIT, `FSS_ERR_BADREQ);
        go(`FSS_REQ_PREOP, 5'h0F, 0, FSS_INIT, `FSS_ERR_MBXCFG);
        go(`FSS_REQ_PREOP, 5'h1C, 0, FSS_PREOP, `FSS_ERR_NONE);
        chk(16'(allow), 16'h8);
    endtask : t_preop
    task automatic t_safeop;
        go(`FSS_REQ_SAFEOP, 5'h1B, 0, FSS_PREOP, `FSS_ERR_PDCFG);
        go(`FSS_REQ_SAFEOP, 5'h1E, 0, FSS_PREOP, `FSS_ERR_DCCFG);
        go(`FSS_REQ_SAFEOP, 5'h1F, 0, FSS_SAFEOP, `FSS_ERR_NONE);
        chk(inImage, 16'hA5C3);
        chk(16'(allow), 16'hB);
        chk(outPins, 16'h0);
        // pins pass two sync stages, the image and its read register
        inPins = 16'h5A3C;
        repeat (5) @(posedge mclk);
        #1;
        chk(inImage, 16'h5A3C);
    endtask : t_safeop
    task automatic t_op;
        go(`FSS_REQ_OP, 5'h1F, 0, FSS_SAFEOP, `FSS_ERR_NOOUT);
        // watchdog off lets safe_operational_state drive the master data
        watchdogEn = 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        chk(outPins, 16'h3C96);
        watchdogEn = 1'b1;
        repeat (2) @(posedge mclk);
        #1;
        chk(outPins, 16'h0000);
        go(`FSS_REQ_OP, 5'h1F, 1, FSS_OP, `FSS_ERR_NONE);
        chk(outPins, 16'h3C96);
        chk(16'(allow), 16'hB);
    endtask : t_op
    task automatic t_boot;
        go(`FSS_REQ_BOOT, 5'h1F, 1, FSS_OP, `FSS_ERR_BADREQ);
        go(`FSS_REQ_INIT, 5'h1F, 1, FSS_INIT, `FSS_ERR_NONE);
        go(`FSS_REQ_BOOT, 5'h1F, 1, FSS_BOOT, `FSS_ERR_NONE);
        chk(16'(allow), 16'hC);
    endtask : t_boot
    // ==========================================================
    // sequence and hang limit
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 2000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    initial begin
        repeat (2) @(posedge mclk);
        #1;
        rst = 0;
        t_reset();
        t_preop();
        t_safeop();
        t_op();
        t_boot();
        report_and_stop();
    end
endmodule : fss_state_machine_bench
